// *** rtl/wdt_consts.svh ***
/*
 Register offsets, field positions, reset values and timing figures of the windowed watchdog.
 Assumes it is included by bare name wherever these constants are used.
*/
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_CLK_PERIOD_NS     10
`define WDT_OSC_FREQ_HZ       32000

`define WDT_OFS_RESET_CTRL    8'h00
`define WDT_OFS_CONFIG        8'h04
`define WDT_OFS_STATUS        8'h08

`define WDT_RC_IDLE_BIT       2
`define WDT_RC_SLEEP_BIT      3
`define WDT_RC_FLAG_BIT       4
`define WDT_RC_SOFT_EN_BIT    5

`define WDT_CFG_POST_MSB      3
`define WDT_CFG_POST_LSB      0
`define WDT_CFG_PRESC_BIT     4
`define WDT_CFG_WINDOW_DISABLE_BIT_BIT    6
`define WDT_CFG_ALWAYS_ON_BIT 7
`define WDT_CFG_RESET         8'h5F
`define WDT_CFG_MASK          8'hDF

`define WDT_PRE_TERM_32       7'h1F
`define WDT_PRE_TERM_128      7'h7F
`define WDT_PRE_SHIFT_32      3'h5
`define WDT_PRE_SHIFT_128     3'h7

`endif

// *** rtl/wdt_pkg.sv ***
/*
 Types shared by the watchdog top level and its bus.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package wdt_pkg;

   typedef logic [7:0]  addr_t;
   typedef logic [31:0] data_t;

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_IDLE} power_state_e;

   typedef struct packed {
      logic         ack;
      data_t        rdata;
      logic         soft_en;
      logic         flag;
      logic         sleep_bit;
      logic         idle_bit;
      logic [7:0]   cfg;
      power_state_e pstate;
      logic [6:0]   pre_cnt;
      logic [14:0]  post_cnt;
      logic         rst_pulse;
      logic         wake_pulse;
   } wdt_state_s;

endpackage

// *** rtl/low_power_rc_osc_osc.sv ***
/*
 Low-power RC oscillator stand-in: a one-cycle tick at the nominal oscillator rate.
 Assumes the system clock period given in the constants header.
*/
`timescale 1ns/1ns
`include "wdt_consts.svh"

module low_power_rc_osc
#(
   parameter int DIV_CYCLES = 1000000000 / (`WDT_CLK_PERIOD_NS * `WDT_OSC_FREQ_HZ),
   parameter int CNT_W      = 12
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic enable_i,
   output logic      tick_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } osc_state_s;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV_CYCLES - 1);

   osc_state_s osc_reg;
   osc_state_s osc_next;

   always_comb
   begin
      osc_next      = osc_reg;
      osc_next.tick = 1'b0;
      // Stopped oscillator restarts from a full period
      if (!enable_i)
      begin
         osc_next.cnt = '0;
      end
      else if (osc_reg.cnt == LAST)
      begin
         osc_next.cnt  = '0;
         osc_next.tick = 1'b1;
      end
      else
      begin
         osc_next.cnt = osc_reg.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         osc_reg <= '0;
      end
      else
      begin
         osc_reg <= osc_next;
      end
   end

   assign tick_o = osc_reg.tick;

endmodule // low_power_rc_osc

// *** rtl/windowed_watchdog_timer.sv ***
/*
 Windowed watchdog timer with Wishbone register access.
 Assumes a classic Wishbone master, core event inputs as one-cycle pulses, and that
 device_reset_i carries every device reset other than power-on.
*/
// The register offsets and the Wishbone register port were left to the implementer.
// Operation
// - Counter runs from the low-power oscillator; enabling the watchdog starts that oscillator.
// - Prescaler divides the oscillator by 32 or by 128 as configured.
// - Prescale select 1 gives divide-by-128, 0 gives divide-by-32.
// - Base period is nominally 1 ms at divide-by-32 and 4 ms at 128.
// - Postscaler divides the prescaler output, 4-bit field, sixteen ratios up to 32768.
// - Postscale field is a power of two: 0000 is 1:1, each step doubles.
// - Any device reset clears counter, prescaler and postscaler.
// - A completed clock switch clears counter and scalers.
// - Entering sleep or idle by power-save instruction clears counter and scalers.
// - Leaving sleep or idle back to running clears counter and scalers.
// - Clear instruction during normal running clears counter and scalers.
// - An enabled watchdog keeps counting during sleep and idle.
// - Timeout in sleep or idle wakes the device to resume execution.
// - Always-on fuse set keeps the watchdog enabled regardless of soft enable.
// - With the fuse clear, soft enable bit starts and stops the watchdog.
// - Every device reset forces the soft enable bit to zero.
// - Window disable bit 1 means normal mode, 0 means window mode.
// - In window mode an early clear instruction raises a watchdog reset.
// - Timeout flag sets on timeout and stays until software clears it.
`timescale 1ns/1ns
`include "wdt_consts.svh"

module windowed_watchdog_timer
#(
   parameter int OSC_DIV_CYCLES = 1000000000 / (`WDT_CLK_PERIOD_NS * `WDT_OSC_FREQ_HZ)
)
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire wdt_pkg::addr_t wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire wdt_pkg::data_t wb_dat_i,
   output wdt_pkg::data_t     wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          device_reset_i,
   input  wire logic          clock_switch_done_i,
   input  wire logic          clear_watchdog_instr_i,
   input  wire logic          power_save_instr_i,
   input  wire logic          power_save_sleep_i,
   input  wire logic          wake_event_i,
   output logic               low_power_rc_osc_en_o,
   output logic               watchdog_reset_o,
   output logic               wake_o
);
   import wdt_pkg::*;

   wdt_state_s  st_reg;
   wdt_state_s  st_next;

   logic        enabled;
   logic        osc_tick;
   logic        prescale_select;
   logic        window_disable_bit;
   logic        always_on_fuse;
   logic [3:0]  postscale_select;
   logic [6:0]  pre_term;
   logic [2:0]  pre_shift;
   logic [14:0] post_term;
   logic        pre_wrap;
   logic        count_step;
   logic        timeout_hit;
   logic        in_run;
   logic        early_fault;
   logic        clear_ok;
   logic        clear_cnt;
   logic [23:0] elapsed;
   logic [23:0] period;
   logic        window_open;
   logic        bus_take;
   data_t       rd_data;

   assign always_on_fuse     = st_reg.cfg[`WDT_CFG_ALWAYS_ON_BIT];
   assign window_disable_bit = st_reg.cfg[`WDT_CFG_WINDOW_DISABLE_BIT_BIT];
   assign prescale_select    = st_reg.cfg[`WDT_CFG_PRESC_BIT];
   assign postscale_select   = st_reg.cfg[`WDT_CFG_POST_MSB:`WDT_CFG_POST_LSB];

   assign enabled               = always_on_fuse | st_reg.soft_en;
   assign low_power_rc_osc_en_o = enabled;

   low_power_rc_osc
   #(
      .DIV_CYCLES (OSC_DIV_CYCLES)
   )
   u_osc
   (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .enable_i (enabled),
      .tick_o   (osc_tick)
   );

   // 32 kHz over 32 gives the 1 ms base, over 128 the 4 ms base
   assign pre_term  = prescale_select ? `WDT_PRE_TERM_128 : `WDT_PRE_TERM_32;
   assign pre_shift = prescale_select ? `WDT_PRE_SHIFT_128 : `WDT_PRE_SHIFT_32;
   assign post_term = 15'((16'h1 << postscale_select) - 16'h1);

   assign pre_wrap    = st_reg.pre_cnt == pre_term;
   assign count_step  = enabled & osc_tick;
   assign timeout_hit = count_step & pre_wrap & (st_reg.post_cnt == post_term);
   assign in_run      = st_reg.pstate == ST_RUN;

   // Elapsed and full period in oscillator ticks; window opens at three quarters
   assign elapsed     = (24'(st_reg.post_cnt) << pre_shift) + 24'(st_reg.pre_cnt);
   assign period      = 24'h1 << (5'(postscale_select) + 5'(pre_shift));
   assign window_open = {elapsed, 2'b00} >= ({2'b00, period} + {1'b0, period, 1'b0});

   assign early_fault = clear_watchdog_instr_i & in_run & enabled & ~window_disable_bit
                        & ~window_open;
   assign clear_ok    = clear_watchdog_instr_i & in_run & ~early_fault;

   assign clear_cnt = device_reset_i
                    | clock_switch_done_i
                    | (power_save_instr_i & in_run)
                    | (~in_run & (timeout_hit | wake_event_i))
                    | clear_ok
                    | timeout_hit | early_fault;

   assign bus_take = wb_cyc_i & wb_stb_i & ~st_reg.ack;

   always_comb
   begin
      rd_data = '0;
      unique case (wb_adr_i)
         `WDT_OFS_RESET_CTRL:
         begin
            rd_data[`WDT_RC_SOFT_EN_BIT] = st_reg.soft_en;
            rd_data[`WDT_RC_FLAG_BIT]    = st_reg.flag;
            rd_data[`WDT_RC_SLEEP_BIT]   = st_reg.sleep_bit;
            rd_data[`WDT_RC_IDLE_BIT]    = st_reg.idle_bit;
         end
         `WDT_OFS_CONFIG:
         begin
            rd_data[7:0] = st_reg.cfg;
         end
         `WDT_OFS_STATUS:
         begin
            rd_data = {2'b00, enabled, window_open, 2'b00, st_reg.pstate, 1'b0,
                       st_reg.post_cnt, 1'b0, st_reg.pre_cnt};
         end
         default:
         begin
            rd_data = '0;
         end
      endcase
   end

   always_comb
   begin
      st_next            = st_reg;
      st_next.ack        = bus_take;
      st_next.rst_pulse  = 1'b0;
      st_next.wake_pulse = 1'b0;

      // Bus write first so hardware sets below win over a same-cycle clear
      if (bus_take)
      begin
         st_next.rdata = rd_data;
         if (wb_we_i && wb_sel_i[0])
         begin
            unique case (wb_adr_i)
               `WDT_OFS_RESET_CTRL:
               begin
                  st_next.soft_en   = wb_dat_i[`WDT_RC_SOFT_EN_BIT];
                  st_next.flag      = wb_dat_i[`WDT_RC_FLAG_BIT];
                  st_next.sleep_bit = wb_dat_i[`WDT_RC_SLEEP_BIT];
                  st_next.idle_bit  = wb_dat_i[`WDT_RC_IDLE_BIT];
               end
               `WDT_OFS_CONFIG:
               begin
                  st_next.cfg = wb_dat_i[7:0] & `WDT_CFG_MASK;
               end
               default:
               begin
               end
            endcase
         end
      end

      if (clear_cnt)
      begin
         st_next.pre_cnt  = '0;
         st_next.post_cnt = '0;
      end
      else if (count_step)
      begin
         if (pre_wrap)
         begin
            st_next.pre_cnt  = '0;
            st_next.post_cnt = st_reg.post_cnt + 15'h1;
         end
         else
         begin
            st_next.pre_cnt = st_reg.pre_cnt + 7'h1;
         end
      end

      if (timeout_hit)
      begin
         st_next.flag = 1'b1;
      end

      unique case (st_reg.pstate)
         ST_RUN:
         begin
            if (power_save_instr_i)
            begin
               if (power_save_sleep_i)
               begin
                  st_next.pstate    = ST_SLEEP;
                  st_next.sleep_bit = 1'b1;
               end
               else
               begin
                  st_next.pstate   = ST_IDLE;
                  st_next.idle_bit = 1'b1;
               end
            end
         end
         ST_SLEEP, ST_IDLE:
         begin
            // Status bits stay set; software owns clearing them
            if (timeout_hit || wake_event_i)
            begin
               st_next.pstate     = ST_RUN;
               st_next.wake_pulse = 1'b1;
            end
         end
      endcase

      if ((timeout_hit && in_run) || early_fault)
      begin
         st_next.rst_pulse = 1'b1;
         st_next.soft_en   = 1'b0;
      end

      if (device_reset_i)
      begin
         st_next.soft_en = 1'b0;
         st_next.pstate  = ST_RUN;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg        <= '0;
         st_reg.cfg    <= `WDT_CFG_RESET;
         st_reg.pstate <= ST_RUN;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign wb_ack_o         = st_reg.ack;
   assign wb_dat_o         = st_reg.rdata;
   assign watchdog_reset_o = st_reg.rst_pulse;
   assign wake_o           = st_reg.wake_pulse;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_osc_follows_enable;
      !low_power_rc_osc_en_o |=> !osc_tick;
   endproperty
   a_osc_follows_enable:
      assert property (p_osc_follows_enable) else $error("oscillator ticked while disabled");

   property p_prescale_wrap;
      (count_step && !clear_cnt && st_reg.pre_cnt == (prescale_select ? 7'h7F : 7'h1F))
      |=> (st_reg.pre_cnt == 7'h00) && (st_reg.post_cnt == $past(st_reg.post_cnt) + 15'h1);
   endproperty
   a_prescale_wrap:
      assert property (p_prescale_wrap) else $error("prescaler wrap point wrong");

   property p_post_terminal;
      (count_step && pre_wrap && st_reg.post_cnt == 15'((16'h1 << postscale_select) - 16'h1))
      |=> st_reg.flag && (st_reg.post_cnt == 15'h0) && (watchdog_reset_o || wake_o);
   endproperty
   a_post_terminal:
      assert property (p_post_terminal) else $error("postscale ratio not honoured");

   property p_scalers_cleared;
      (device_reset_i || clock_switch_done_i || clear_ok)
      |=> (st_reg.pre_cnt == 7'h00) && (st_reg.post_cnt == 15'h0000);
   endproperty
   a_scalers_cleared:
      assert property (p_scalers_cleared) else $error("counter not cleared by event");

   property p_enter_low_power;
      (in_run && power_save_instr_i && !device_reset_i)
      |=> (st_reg.pstate != ST_RUN) && (st_reg.pre_cnt == 7'h00) && (st_reg.post_cnt == 15'h0);
   endproperty
   a_enter_low_power:
      assert property (p_enter_low_power) else $error("power save entry wrong");

   property p_count_in_sleep;
      (!in_run && count_step && !pre_wrap && !clear_cnt)
      |=> st_reg.pre_cnt == $past(st_reg.pre_cnt) + 7'h1;
   endproperty
   a_count_in_sleep:
      assert property (p_count_in_sleep) else $error("no counting in sleep or idle");

   property p_wake_on_timeout;
      (!in_run && timeout_hit && !device_reset_i)
      |=> wake_o && (st_reg.pstate == ST_RUN) && !watchdog_reset_o && st_reg.post_cnt == 15'h0;
   endproperty
   a_wake_on_timeout:
      assert property (p_wake_on_timeout) else $error("timeout did not wake");

   property p_run_timeout_reset;
      (in_run && timeout_hit) |=> watchdog_reset_o ##1 !watchdog_reset_o;
   endproperty
   a_run_timeout_reset:
      assert property (p_run_timeout_reset) else $error("timeout reset pulse wrong");

   property p_early_clear;
      (clear_watchdog_instr_i && in_run && enabled && !window_disable_bit && !window_open)
      |=> watchdog_reset_o && !st_reg.soft_en;
   endproperty
   a_early_clear:
      assert property (p_early_clear) else $error("early clear did not reset");

   property p_flag_sticky;
      st_reg.flag && !(bus_take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
      |=> st_reg.flag;
   endproperty
   a_flag_sticky:
      assert property (p_flag_sticky) else $error("timeout flag dropped");

   property p_flag_set_wins;
      timeout_hit |=> st_reg.flag;
   endproperty
   a_flag_set_wins:
      assert property (p_flag_set_wins) else $error("timeout flag not set");

   property p_soft_enable_reset;
      device_reset_i |=> !st_reg.soft_en && (st_reg.pstate == ST_RUN);
   endproperty
   a_soft_enable_reset:
      assert property (p_soft_enable_reset) else $error("soft enable survived reset");

   c_run_timeout:  cover property (in_run && timeout_hit);
   c_sleep_wake:   cover property (st_reg.pstate == ST_SLEEP && timeout_hit);
   c_early_clear:  cover property (early_fault);
   c_window_clear: cover property (clear_ok && !window_disable_bit && enabled);

endmodule // windowed_watchdog_timer

// *** dv/windowed_watchdog_timer_bench.sv ***
/*
 Self-checking bench for the windowed watchdog: bus access, clear events, power save, timeout.
 Assumes the oscillator divider is shortened to TICK system clocks so the run stays short.
*/
`timescale 1ns/1ns

module windowed_watchdog_timer_bench;
   import wdt_pkg::*;

   localparam int TICK = 50;

   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   addr_t       wb_adr_i;
   logic [3:0]  wb_sel_i;
   data_t       wb_dat_i;
   data_t       wb_dat_o;
   logic        wb_ack_o;
   logic [4:0]  ev;
   logic        power_save_sleep_i;
   logic        osc_en;
   logic        wd_rst;
   logic        wake;
   logic [31:0] seed;
   int          num_errors;
   int          n_tests;
   int          n_rst;
   int          n_wake;
   int          cyc_cnt;

   windowed_watchdog_timer
   #(
      .OSC_DIV_CYCLES (TICK)
   )
   dut_u
   (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .wb_cyc_i               (wb_cyc_i),
      .wb_stb_i               (wb_stb_i),
      .wb_we_i                (wb_we_i),
      .wb_adr_i               (wb_adr_i),
      .wb_sel_i               (wb_sel_i),
      .wb_dat_i               (wb_dat_i),
      .wb_dat_o               (wb_dat_o),
      .wb_ack_o               (wb_ack_o),
      .device_reset_i         (ev[2]),
      .clock_switch_done_i    (ev[1]),
      .clear_watchdog_instr_i (ev[0]),
      .power_save_instr_i     (ev[4]),
      .power_save_sleep_i     (power_save_sleep_i),
      .wake_event_i           (ev[3]),
      .low_power_rc_osc_en_o  (osc_en),
      .watchdog_reset_o       (wd_rst),
      .wake_o                 (wake)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Pulse outputs last one cycle, so count them at every edge
   always @(posedge clk_i)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (wd_rst === 1'b1)
         n_rst <= n_rst + 1;
      if (wake === 1'b1)
         n_wake <= n_wake + 1;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic summarize();
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   task automatic bus(input logic we, input addr_t adr, input data_t dat,
                      input logic [3:0] sel, output data_t rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20)
         check("bus_ack", 32'h1, 32'h0);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input addr_t adr, input data_t dat);
      data_t d;
      bus(1'b1, adr, dat, 4'hF, d);
   endtask

   task automatic rd(input addr_t adr, output data_t d);
      bus(1'b0, adr, 32'h0, 4'hF, d);
   endtask

   task automatic pulse(input int which);
      @(posedge clk_i);
      ev[which] <= 1'b1;
      @(posedge clk_i);
      ev <= 5'h00;
   endtask

   // Returns right after the prescaler count moves, leaving a full tick of quiet
   task automatic wait_tick(output int t);
      data_t s;
      logic [6:0] p;
      int n;
      rd(8'h08, s);
      p = s[6:0];
      n = 0;
      do
      begin
         rd(8'h08, s);
         n++;
      end while (s[6:0] === p && n < TICK);
      check("tick_seen", 32'h1, {31'h0, n < TICK});
      t = cyc_cnt;
   endtask

   initial
   begin
      // About 300 oscillator ticks of scenarios, with ample margin
      repeat (600 * TICK) @(posedge clk_i);
      num_errors++;
      summarize();
   end

   initial
   begin
      data_t d;
      int t0;
      int t1;
      int k;
      int nt;
      int r0;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      ev = 5'h00;
      power_save_sleep_i = 1'b0;
      {num_errors, n_tests, n_rst, n_wake, cyc_cnt} = '0;
      seed = 32'hB172;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h04, d);
      check("cfg_reset", 32'h5F, d);
      rd(8'h00, d);
      check("rc_reset", 32'h0, d);
      check("osc_en_reset", 32'h0, {31'h0, osc_en});
      rd(8'h0C, d);
      check("unmapped", 32'h0, d);
      for (k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         wr(8'h04, seed);
         rd(8'h04, d);
         check("cfg_rw", {24'h0, seed[7:0] & 8'hDF}, d);
      end
      bus(1'b1, 8'h04, 32'h0, 4'h0, d);
      rd(8'h04, d);
      check("cfg_sel_off", {24'h0, seed[7:0] & 8'hDF}, d);
      wr(8'h04, 32'hC0);
      wr(8'h00, 32'h0);
      check("osc_fuse", 32'h1, {31'h0, osc_en});
      wr(8'h04, 32'h40);
      check("osc_soft_off", 32'h0, {31'h0, osc_en});
      wr(8'h00, 32'h20);
      check("osc_soft_on", 32'h1, {31'h0, osc_en});
      wait_tick(t0);
      wait_tick(t1);
      check("tick_rate", 32'h1, {31'h0, (t1 - t0 >= TICK - 3) && (t1 - t0 <= TICK + 3)});
      // Clear sources: instruction, clock switch, device reset
      for (k = 0; k < 3; k++)
      begin
         wait_tick(t0);
         seed = xs(seed);
         repeat (seed % (TICK / 2)) @(posedge clk_i);
         pulse(k);
         rd(8'h08, d);
         check("counts_cleared", 32'h0, {9'h0, d[22:8], 1'b0, d[6:0]});
      end
      rd(8'h00, d);
      check("soft_en_dev_rst", 32'h0, {31'h0, d[5]});
      check("osc_after_rst", 32'h0, {31'h0, osc_en});
      wr(8'h00, 32'h20);
      for (k = 0; k < 2; k++)
      begin
         wait_tick(t0);
         power_save_sleep_i <= k[0];
         pulse(4);
         rd(8'h08, d);
         check("ps_state", {30'h0, ~k[0], k[0]}, {30'h0, d[25:24]});
         check("ps_counts", 32'h0, {9'h0, d[22:8], 1'b0, d[6:0]});
         rd(8'h00, d);
         check("ps_bits", {28'h0, k[0], ~k[0], 2'b00}, {28'h0, d[3:2], 2'b00});
         t1 = n_wake;
         wait_tick(t0);
         pulse(3);
         rd(8'h08, d);
         check("wake_pulse", t1 + 1, n_wake);
         check("wake_state", 32'h0, {8'h0, d[22:8], d[25:24], d[6:0]});
         wr(8'h00, 32'h20);
      end
      // Early clear in window mode
      wr(8'h04, 32'h00);
      t1 = n_rst;
      pulse(0);
      rd(8'h00, d);
      check("early_clear_rst", t1 + 1, n_rst);
      check("early_clear_rc", 32'h0, {26'h0, d[5:4], 4'h0});
      // Clear inside the last quarter is accepted in window mode
      wr(8'h00, 32'h20);
      r0 = n_rst;
      repeat (25) wait_tick(t0);
      rd(8'h08, d);
      check("window_open", 32'h1, {31'h0, d[28]});
      pulse(0);
      rd(8'h08, d);
      check("window_clear_counts", 32'h0, {9'h0, d[22:8], 1'b0, d[6:0]});
      check("window_clear_no_rst", r0, n_rst);
      // Full timeouts while asleep: ratios 1 and 2 at divide-by-32, ratio 1 at divide-by-128
      for (k = 0; k < 3; k++)
      begin
         nt = (k == 2) ? 128 : 32 << k;
         wr(8'h04, (k == 2) ? 32'h50 : 32'h40 + k);
         power_save_sleep_i <= 1'b1;
         t1 = n_wake;
         r0 = n_rst;
         pulse(4);
         t0 = cyc_cnt;
         while (n_wake == t1 && cyc_cnt - t0 < (nt + 2) * TICK)
            @(posedge clk_i);
         t0 = cyc_cnt - t0;
         check("sleep_timeout_wake", t1 + 1, n_wake);
         check("sleep_timeout_time", 32'h1,
               {31'h0, t0 > (nt - 1) * TICK && t0 <= (nt + 1) * TICK});
         check("sleep_no_reset", r0, n_rst);
         rd(8'h00, d);
         check("flag_and_sleep", 32'h38, {26'h0, d[5:2], 2'b00});
         rd(8'h08, d);
         check("state_run", 32'h0, {30'h0, d[25:24]});
         rd(8'h00, d);
         check("flag_sticky", 32'h1, {31'h0, d[4]});
         wr(8'h00, 32'h20);
         rd(8'h00, d);
         check("flag_cleared", 32'h20, {26'h0, d[5:2], 2'b00});
      end
      // Unserviced timeout while running resets the device
      wr(8'h04, 32'h40);
      r0 = n_rst;
      t0 = cyc_cnt;
      while (n_rst == r0 && cyc_cnt - t0 < 34 * TICK)
         @(posedge clk_i);
      check("run_timeout_rst", r0 + 1, n_rst);
      rd(8'h00, d);
      check("run_timeout_rc", 32'h10, {26'h0, d[5:4], 4'h0});
      summarize();
   end

endmodule // windowed_watchdog_timer_bench
